// ---- core/timer_pkg.sv ----
package timer_pkg;

   // Register map, byte addresses on the Avalon-MM slave
   localparam logic [3:0] OPTION_OFS  = 4'h0;
   localparam logic [3:0] COUNT_OFS   = 4'h4;
   localparam logic [3:0] INTCTL_OFS  = 4'h8;
   localparam logic [3:0] STATUS_OFS  = 4'hc;

   // Option control register fields
   localparam int SRC_SEL_BIT  = 5;
   localparam int EDGE_SEL_BIT = 4;
   localparam int PS_ASSIGN_BIT = 3;
   localparam int RATE_LSB     = 0;
   localparam int RATE_W       = 3;

   // Interrupt control register fields
   localparam int OVF_EN_BIT   = 0;
   localparam int OVF_FLAG_BIT = 1;

   // Status register fields
   localparam int STAT_INHIBIT_BIT = 0;
   localparam int STAT_SLEEP_BIT   = 1;
   localparam int STAT_PENDING_BIT = 2;

   // Reset values and the count maximum
   localparam logic [7:0] OPTION_RST = 8'hff;
   localparam logic [7:0] COUNT_RST  = 8'h00;
   localparam logic [7:0] COUNT_MAX  = 8'hff;

   // Instruction cycle: four clock phases
   localparam logic [1:0] PHASE_Q1 = 2'h0;
   localparam logic [1:0] PHASE_Q2 = 2'h1;
   localparam logic [1:0] PHASE_Q4 = 2'h3;

   // Instruction cycles of increment lockout after a count write
   localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_t;

   // Low-bit mask at which the prescaler emits; wdt ratios are one step lower
   function automatic logic [7:0] rate_mask(input logic [2:0] rate, input logic to_wdt);
      logic [3:0] sh;
      logic [8:0] ones;
      sh   = {1'b0, rate} + {3'h0, ~to_wdt};
      ones = (9'h001 << sh) - 9'h001;
      rate_mask = ones[7:0];
   endfunction

endpackage

// ---- core/edge_sync.sv ----
`timescale 1ns/1ps
module edge_sync
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic core_clk_in,
   input  wire logic arst_n_in,
   input  wire logic ce_in,
   // Pin and selection
   input  wire logic pin_in,
   input  wire logic falling_in,
   // Detected edge
   output logic      edge_out
);

   logic meta_q;
   logic sync_q;
   logic prev_q;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else if (ce_in) begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Polarity picks which transition counts
   assign edge_out = ce_in & (falling_in ? (prev_q & ~sync_q) : (~prev_q & sync_q)); // RULE_05 RULE_17

endmodule

// ---- core/shared_prescaler.sv ----
`timescale 1ns/1ps
module shared_prescaler
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic             core_clk_in,
   input  wire logic             arst_n_in,
   input  wire logic             ce_in,
   // Control
   input  wire logic             tick_in,
   input  wire logic             clear_in,
   input  wire logic [RATE_W-1:0] rate_in,
   input  wire logic             to_wdt_in,
   // Divided output
   output logic                  tick_out
);

   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [7:0] mask;

   assign mask     = rate_mask(rate_in, to_wdt_in); // RULE_07 RULE_08 RULE_16
   assign tick_out = ce_in & tick_in & ~clear_in & ((cnt_q & mask) == mask);
   // Count is internal only; clear beats an incoming tick
   assign cnt_d    = clear_in ? 8'h00 : (tick_in ? cnt_q + 8'h01 : cnt_q); // RULE_09

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_q <= 8'h00;
      end else if (ce_in) begin
         cnt_q <= cnt_d;
      end
   end

endmodule

// ---- core/count_timer.sv ----
// Overview of operation
// RULE_01 - Eight-bit count register, software readable and writable, timer or counter.
// RULE_02 - Source select clear: advance each instruction cycle when prescaler is elsewhere.
// RULE_03 - After a count write, no increment for the next two instruction cycles.
// RULE_04 - Source select set: advance on edges of the external count pin.
// RULE_05 - Edge select bit chooses rising or falling pin transition.
// RULE_06 - One prescaler serves timer or watchdog; assign bit zero gives it here.
// RULE_07 - Assigned here, three-bit rate gives eight ratios 1:2 to 1:256.
// RULE_08 - Undivided counting only when the prescaler belongs to the watchdog.
// RULE_09 - Prescaler count hidden; count writes clear it while assigned here.
// RULE_10 - Watchdog clear instruction clears prescaler while assigned to watchdog.
// RULE_11 - Wrap from maximum to zero sets overflow flag regardless of enable.
// RULE_12 - Hardware never clears overflow flag; software clears it by writing zero.
// RULE_13 - Interrupt request only when flag and overflow enable are both set.
// RULE_14 - During sleep the counter holds and cannot overflow.
// RULE_15 - Overflow-derived gate output for the sixteen-bit timer.
// RULE_16 - Rate codes map to timer 1:2..1:256, watchdog 1:1..1:128.
// RULE_17 - Edge select one counts falling edges, zero counts rising edges.
// RULE_18 - Counter mode events are synchronised at the second and fourth phases.
// RULE_19 - Option register resets to all ones.
// RULE_20 - Flag sets in the wrap cycle; a software write beats an increment.
`timescale 1ns/1ps
module count_timer
   import timer_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        core_clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        ce_in,

   // Avalon-MM slave
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,

   // Core and watchdog side
   input  wire logic        sleep_in,
   input  wire logic        wdt_clear_in,
   input  wire logic        wdt_tick_in,
   output logic             wdt_tick_out,

   // External count pin
   input  wire logic        ext_count_input_in,

   // Events
   output logic             ovf_request_out,
   output logic             gate_out
);

   // Registers
   logic [7:0]  option_q;
   logic [7:0]  option_d;
   logic [7:0]  count_register_q;
   logic [7:0]  count_register_d;
   logic        overflow_int_enable_q;
   logic        overflow_int_enable_d;
   logic        overflow_flag_q;
   logic        overflow_flag_d;
   logic [1:0]  phase_q;
   logic [1:0]  inhibit_q;
   logic [1:0]  inhibit_d;
   logic        pending_q;
   logic        pending_d;
   bus_state_t  bus_q;
   bus_state_t  bus_d;
   logic [31:0] readdata_q;
   logic [31:0] readdata_d;
   logic        waitrequest_q;
   logic        ovf_request_q;
   logic        gate_q;
   logic        wdt_tick_q;

   // Option fields
   wire logic              count_source_select = option_q[SRC_SEL_BIT];
   wire logic              source_edge_select  = option_q[EDGE_SEL_BIT];
   wire logic              prescaler_assign    = option_q[PS_ASSIGN_BIT];
   wire logic [RATE_W-1:0] prescale_rate       = option_q[RATE_LSB +: RATE_W];

   // Phase decode
   wire logic instr_tick = ce_in & (phase_q == PHASE_Q4);
   wire logic q2_or_q4   = ce_in & ((phase_q == PHASE_Q2) | (phase_q == PHASE_Q4)); // RULE_18

   // Address match, shared by the write strobes and the read mux
   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
      reg_hit = (addr == ofs);
   endfunction

   // Bus decode
   wire logic req       = avs_read_in | avs_write_in;
   wire logic take      = req & (bus_q == BUS_IDLE);
   wire logic commit    = req & (bus_q == BUS_ACK);
   wire logic wr_commit = commit & avs_write_in & avs_byteenable_in[0];
   wire logic wr_option = wr_commit & reg_hit(avs_address_in, OPTION_OFS);
   wire logic wr_count  = wr_commit & reg_hit(avs_address_in, COUNT_OFS);
   wire logic wr_intctl = wr_commit & reg_hit(avs_address_in, INTCTL_OFS);
   wire logic rd_take   = take & avs_read_in;

   // Count source
   logic ext_edge;
   logic pre_in;
   logic pre_out;
   logic pre_clear;
   logic timer_src;
   logic scaled_src;
   logic inc_event;
   logic wrap;

   // Lockout gates every increment path
   wire logic lockout_idle = (inhibit_q == 2'h0);
   wire logic inc_ok       = inc_event & lockout_idle;

   edge_sync u_edge_sync (
      .core_clk_in (core_clk_in),
      .arst_n_in   (arst_n_in),
      .ce_in       (ce_in),
      .pin_in      (ext_count_input_in),
      .falling_in  (source_edge_select),
      .edge_out    (ext_edge)
   );

   // Sleep freezes the timer path only; the watchdog path keeps running
   assign timer_src = ~sleep_in & (count_source_select ? ext_edge : instr_tick); // RULE_02 RULE_04 RULE_14

   // Prescaler sits on one side or the other, never both
   assign pre_in    = prescaler_assign ? wdt_tick_in : timer_src; // RULE_06
   assign pre_clear = prescaler_assign ? wdt_clear_in : wr_count; // RULE_09 RULE_10

   shared_prescaler u_prescaler (
      .core_clk_in (core_clk_in),
      .arst_n_in   (arst_n_in),
      .ce_in       (ce_in),
      .tick_in     (pre_in),
      .clear_in    (pre_clear),
      .rate_in     (prescale_rate),
      .to_wdt_in   (prescaler_assign),
      .tick_out    (pre_out)
   );

   // Undivided path only when the prescaler went to the watchdog
   assign scaled_src = prescaler_assign ? timer_src : (pre_out & ~sleep_in); // RULE_08

   // Watchdog sees the divided tick only while it owns the prescaler
   logic wdt_tick_d;
   assign wdt_tick_d = prescaler_assign ? pre_out : wdt_tick_in; // RULE_06

   // Pin events wait for a Q2/Q4 sample; timer events already sit on Q4
   always_comb begin
      pending_d = pending_q;
      inc_event = 1'b0;
      if (count_source_select) begin
         if (scaled_src) begin
            pending_d = 1'b1;
         end
         if (pending_q & q2_or_q4 & ~sleep_in) begin
            inc_event = 1'b1; // RULE_18
            pending_d = scaled_src;
         end
      end else begin
         pending_d = 1'b0;
         inc_event = scaled_src;
      end
   end

   // Lockout counts down on instruction boundaries
   always_comb begin
      inhibit_d = inhibit_q;
      if (wr_count) begin
         inhibit_d = INHIBIT_CYCLES; // RULE_03
      end else if (instr_tick & ~lockout_idle) begin
         inhibit_d = inhibit_q - 2'h1;
      end
   end

   // Count register: a write wins over a same-cycle increment
   assign wrap = inc_ok & ~wr_count & (count_register_q == COUNT_MAX);

   always_comb begin
      count_register_d = count_register_q;
      if (wr_count) begin
         count_register_d = avs_writedata_in[7:0]; // RULE_01 RULE_20
      end else if (inc_ok) begin
         count_register_d = count_register_q + 8'h01; // RULE_03
      end
   end

   // Overflow flag: a wrap in the clearing cycle still sets it
   always_comb begin
      overflow_flag_d = overflow_flag_q;
      if (wr_intctl) begin
         overflow_flag_d = avs_writedata_in[OVF_FLAG_BIT]; // RULE_12
      end
      if (wrap) begin
         overflow_flag_d = 1'b1; // RULE_11 RULE_20
      end
   end

   assign overflow_int_enable_d = wr_intctl ? avs_writedata_in[OVF_EN_BIT] : overflow_int_enable_q;
   assign option_d = wr_option ? avs_writedata_in[7:0] : option_q;

   // Bus: one wait state, read data captured while waitrequest is high
   always_comb begin
      bus_d = bus_q;
      case (bus_q)
         BUS_IDLE: begin
            if (req) begin
               bus_d = BUS_ACK;
            end
         end
         BUS_ACK: begin
            bus_d = BUS_IDLE;
         end
         default: begin
            bus_d = BUS_IDLE;
         end
      endcase
   end

   // Packed read views of the flag and status bits
   logic [7:0] intctl_view;
   logic [7:0] status_view;

   always_comb begin
      intctl_view                   = 8'h00;
      intctl_view[OVF_EN_BIT]       = overflow_int_enable_q;
      intctl_view[OVF_FLAG_BIT]     = overflow_flag_q;
      status_view                   = 8'h00;
      status_view[STAT_INHIBIT_BIT] = ~lockout_idle;
      status_view[STAT_SLEEP_BIT]   = sleep_in;
      status_view[STAT_PENDING_BIT] = pending_q;
   end

   always_comb begin
      readdata_d = readdata_q;
      if (rd_take) begin
         if (reg_hit(avs_address_in, OPTION_OFS)) begin
            readdata_d = {24'h000000, option_q};
         end else if (reg_hit(avs_address_in, COUNT_OFS)) begin
            readdata_d = {24'h000000, count_register_q};
         end else if (reg_hit(avs_address_in, INTCTL_OFS)) begin
            readdata_d = {24'h000000, intctl_view};
         end else if (reg_hit(avs_address_in, STATUS_OFS)) begin
            readdata_d = {24'h000000, status_view};
         end else begin
            readdata_d = 32'h00000000;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         option_q              <= OPTION_RST; // RULE_19
         count_register_q      <= COUNT_RST;
         overflow_int_enable_q <= 1'b0;
         overflow_flag_q       <= 1'b0;
         phase_q               <= PHASE_Q1;
         inhibit_q             <= 2'h0;
         pending_q             <= 1'b0;
      end else if (ce_in) begin
         option_q              <= option_d;
         count_register_q      <= count_register_d;
         overflow_int_enable_q <= overflow_int_enable_d;
         overflow_flag_q       <= overflow_flag_d;
         phase_q               <= phase_q + 2'h1;
         inhibit_q             <= inhibit_d;
         pending_q             <= pending_d;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bus_q         <= BUS_IDLE;
         readdata_q    <= 32'h00000000;
         waitrequest_q <= 1'b1;
      end else if (ce_in) begin
         bus_q         <= bus_d;
         readdata_q    <= readdata_d;
         waitrequest_q <= ~(take);
      end
   end

   // Outputs, all registered
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ovf_request_q <= 1'b0;
         gate_q        <= 1'b0;
         wdt_tick_q    <= 1'b0;
      end else if (ce_in) begin
         ovf_request_q <= overflow_flag_d & overflow_int_enable_d; // RULE_13
         gate_q        <= wrap; // RULE_15
         wdt_tick_q    <= wdt_tick_d;
      end
   end

   assign avs_readdata_out    = readdata_q;
   assign avs_waitrequest_out = waitrequest_q;
   assign ovf_request_out     = ovf_request_q;
   assign gate_out            = gate_q;
   assign wdt_tick_out        = wdt_tick_q;

endmodule

// ---- dv/count_timer_chk.sv ----
`timescale 1ns/1ps
module count_timer_chk (
   // Clock and bus
   input wire logic        core_clk_in,
   input wire logic        arst_n_in,
   input wire logic        ce_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   // Core, watchdog, events
   input wire logic        sleep_in,
   input wire logic        wdt_tick_in,
   input wire logic        wdt_tick_out,
   input wire logic        ovf_request_out,
   input wire logic        gate_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   property p_wait_one;
      (avs_read_in || avs_write_in) && avs_waitrequest_out && ce_in |=> !avs_waitrequest_out;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("no answer after one wait");
   property p_wait_pulse; !avs_waitrequest_out && ce_in |=> avs_waitrequest_out; endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest held low");
   property p_upper; !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_rd_hold; !$past(avs_read_in) |-> $stable(avs_readdata_out); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   // Enable or flag writes land one or two cycles before the request drops
   property p_flag_hold;
      $fell(ovf_request_out) |-> $past(avs_write_in) || $past(avs_write_in, 2);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hardware");
   property p_ovf_gate;
      $rose(ovf_request_out) && !$past(avs_write_in) && !$past(avs_write_in, 2) |-> gate_out;
   endproperty
   a_ovf_gate: assert property (p_ovf_gate) else $error("no gate pulse after wrap");
   property p_gate_pulse; gate_out |=> !gate_out; endproperty
   a_gate_pulse: assert property (p_gate_pulse) else $error("gate pulse too long");
   property p_sleep; sleep_in && $past(sleep_in) && $past(sleep_in, 2) |-> !gate_out; endproperty
   a_sleep: assert property (p_sleep) else $error("wrap during sleep");
   property p_wdt_src; wdt_tick_out |-> $past(wdt_tick_in); endproperty
   a_wdt_src: assert property (p_wdt_src) else $error("watchdog tick without source");
   c_write: cover property (avs_write_in && !avs_waitrequest_out);
   c_gate: cover property (gate_out);
   c_ovf: cover property (ovf_request_out);
   c_wdt: cover property (wdt_tick_out);
endmodule

bind count_timer count_timer_chk u_chk (
   .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .sleep_in(sleep_in), .wdt_tick_in(wdt_tick_in), .wdt_tick_out(wdt_tick_out),
   .ovf_request_out(ovf_request_out), .gate_out(gate_out)
);

// ---- dv/timer_partner.sv ----
`timescale 1ns/1ps
module timer_partner (
   // Clock
   input  wire logic core_clk_in,
   // Pin and watchdog base tick
   output logic      pin_out,
   output logic      tick_out
);
   initial begin
      pin_out = 1'b0;
      tick_out = 1'b0;
   end
   // Ten clocks per level keeps each phase above the eight-clock minimum
   task automatic toggle_pin(input int n);
      repeat (n) begin
         repeat (10) @(posedge core_clk_in);
         pin_out <= ~pin_out;
      end
   endtask
   task automatic pulse_wdt(input int n);
      repeat (n) begin
         @(posedge core_clk_in);
         tick_out <= 1'b1;
         @(posedge core_clk_in);
         tick_out <= 1'b0;
         @(posedge core_clk_in);
      end
   endtask
endmodule

// ---- dv/eight_bit_timer_counter_tb.sv ----
`timescale 1ns/1ps
module eight_bit_timer_counter_tb;
   import timer_pkg::*;
   logic        core_clk_in, arst_n_in, ce_in, sleep_in, wdt_clear_in, wdt_tick_in;
   logic [3:0]  avs_address_in, avs_byteenable_in;
   logic        avs_read_in, avs_write_in, avs_waitrequest_out, wdt_tick_out;
   logic [31:0] avs_writedata_in, avs_readdata_out;
   logic        ext_count_input_in, ovf_request_out, gate_out;
   logic [7:0]  exp_q[$];
   int          errors, num_checks, wdt_seen;

   initial begin
      core_clk_in = 1'b0;
      forever #10 core_clk_in = ~core_clk_in;
   end

   count_timer DUT (
      .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .sleep_in(sleep_in),
      .wdt_clear_in(wdt_clear_in), .wdt_tick_in(wdt_tick_in), .wdt_tick_out(wdt_tick_out),
      .ext_count_input_in(ext_count_input_in), .ovf_request_out(ovf_request_out),
      .gate_out(gate_out)
   );
   timer_partner u_far (
      .core_clk_in(core_clk_in), .pin_out(ext_count_input_in), .tick_out(wdt_tick_in)
   );

   task automatic complete_run();
      if (errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_ack();
      int n;
      n = 0;
      @(posedge core_clk_in);
      while (avs_waitrequest_out !== 1'b0) begin
         n++;
         if (n > 20) begin
            errors++;
            $display("[ERR] %0t bus timeout", $time);
            complete_run();
         end
         @(posedge core_clk_in);
      end
   endtask

   task automatic bw(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
      avs_address_in <= a;
      avs_writedata_in <= {24'h0, d};
      avs_byteenable_in <= be;
      avs_write_in <= 1'b1;
      wait_ack();
      avs_write_in <= 1'b0;
      @(posedge core_clk_in);
   endtask

   task automatic br(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      avs_address_in <= a;
      avs_read_in <= 1'b1;
      wait_ack();
      avs_read_in <= 1'b0;
      @(posedge core_clk_in);
   endtask

   // Read data and watchdog ticks are judged where they appear
   always @(posedge core_clk_in) begin
      if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0)
         chk(avs_readdata_out, {24'h0, exp_q.pop_front()});
      if (wdt_tick_out === 1'b1)
         wdt_seen++;
   end

   // Phase of the write within the instruction cycle is unknown, hence the window
   // A clock-enable pause delays every event alike, so the window still holds
   task automatic run_wrap(input logic [7:0] opt, input int ratio, input int frz);
      logic [7:0] v;
      int         d, n, lo, hi;
      v = 8'hf0 | 8'($urandom % 16);
      d = 256 - int'(v);
      lo = 4 * (d * ratio + ((ratio == 1) ? 2 : 0)) - 4;
      hi = 4 * (d * ratio + 2) + 4;
      bw(OPTION_OFS, opt, 4'h1);
      bw(COUNT_OFS, v, 4'h1);
      if (frz > 0) begin
         ce_in <= 1'b0;
         repeat (frz) @(posedge core_clk_in);
         ce_in <= 1'b1;
      end
      n = 0;
      while (gate_out !== 1'b1 && n <= hi) begin
         @(posedge core_clk_in);
         n++;
      end
      chk({31'h0, n >= lo && n <= hi}, 32'h1);
      if (n > hi)
         complete_run();
   endtask

   task automatic cnt_run(input logic [7:0] opt, input int div);
      int n, k;
      n = 3 + int'($urandom % 6);
      bw(OPTION_OFS, opt, 4'h1);
      bw(COUNT_OFS, 8'h00, 4'h1);
      k = (u_far.pin_out ^ opt[EDGE_SEL_BIT]) ? n / 2 : (n + 1) / 2;
      u_far.toggle_pin(n);
      repeat (20) @(posedge core_clk_in);
      br(COUNT_OFS, 8'(k / div));
   endtask

   initial begin
      {arst_n_in, sleep_in, wdt_clear_in, avs_read_in, avs_write_in} = 5'h00;
      ce_in = 1'b1;
      avs_address_in = 4'h0;
      avs_byteenable_in = 4'h0;
      avs_writedata_in = 32'h0;
      errors = 0;
      num_checks = 0;
      wdt_seen = 0;
      void'($urandom(32'hfc93));
      repeat (2) @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      @(posedge core_clk_in);
      br(OPTION_OFS, OPTION_RST);
      br(COUNT_OFS, COUNT_RST);
      br(INTCTL_OFS, 8'h00);
      bw(4'h1, 8'h55, 4'h1);
      br(4'h1, 8'h00);
      bw(COUNT_OFS, 8'h33, 4'h0);
      br(COUNT_OFS, 8'h00);
      run_wrap(8'h08, 1, 40);
      br(INTCTL_OFS, 8'h02);
      chk({31'h0, ovf_request_out}, 32'h0);
      bw(INTCTL_OFS, 8'h00, 4'h1);
      br(INTCTL_OFS, 8'h00);
      bw(INTCTL_OFS, 8'h01, 4'h1);
      for (int r = 0; r < 8; r++)
         run_wrap(8'(r), 2 << r, 0);
      chk({31'h0, ovf_request_out}, 32'h1);
      br(INTCTL_OFS, 8'h03);
      cnt_run(8'h28, 1);
      cnt_run(8'h38, 1);
      cnt_run(8'h20, 2);
      bw(OPTION_OFS, 8'h08, 4'h1);
      sleep_in <= 1'b1;
      repeat (5) @(posedge core_clk_in);
      br(STATUS_OFS, 8'h02);
      bw(STATUS_OFS, 8'hff, 4'h1);
      br(STATUS_OFS, 8'h02);
      bw(COUNT_OFS, 8'h5a, 4'h1);
      repeat (200) @(posedge core_clk_in);
      br(COUNT_OFS, 8'h5a);
      sleep_in <= 1'b0;
      bw(OPTION_OFS, 8'h0a, 4'h1);
      wdt_seen = 0;
      // Second clear must drop the two pulses left by the first pass
      for (int i = 0; i < 2; i++) begin
         wdt_clear_in <= 1'b1;
         @(posedge core_clk_in);
         wdt_clear_in <= 1'b0;
         u_far.pulse_wdt(2 + 5 * i);
      end
      repeat (4) @(posedge core_clk_in);
      chk(32'(wdt_seen), 32'h1);
      bw(OPTION_OFS, 8'h00, 4'h1);
      wdt_seen = 0;
      u_far.pulse_wdt(5);
      repeat (4) @(posedge core_clk_in);
      chk(32'(wdt_seen), 32'h5);
      complete_run();
   end
endmodule
